//--- logic/ddr_io_element.sv
// ddr i/o element datapath: strobe capture, read fifo, output serializer, delay config chain
`timescale 1ns/100ps

// dual-clock fifo with gray pointers and registered ready/valid
module async_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         wr_clk_i,
  input  wire logic         rd_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] TOP2 = {2'b11, {(AW-1){1'b0}}};

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin;
  logic [AW:0]  wgray;
  logic [AW:0]  rbin;
  logic [AW:0]  rgray;
  logic [AW:0]  rgray_w1;
  logic [AW:0]  rgray_w2;
  logic [AW:0]  wgray_r1;
  logic [AW:0]  wgray_r2;
  logic [AW:0]  next_wbin;
  logic [AW:0]  next_wgray;
  logic [AW:0]  next_rbin;
  logic [AW:0]  next_rgray;
  logic         push;
  logic         pop;

  assign push       = in_valid_i & in_ready_o;
  assign pop        = out_valid_o & out_ready_i;
  assign next_wbin  = wbin + (AW+1)'(push);
  assign next_wgray = (next_wbin >> 1) ^ next_wbin;
  assign next_rbin  = rbin + (AW+1)'(pop);
  assign next_rgray = (next_rbin >> 1) ^ next_rbin;
  assign out_data_o = mem[rbin[AW-1:0]];

  // storage written only on the filling side
  always_ff @(posedge wr_clk_i)
  begin
    if (push)
      mem[wbin[AW-1:0]] <= in_data_i;
  end

  // write side: pointer and registered ready, full seen against a synced read pointer
  always_ff @(posedge wr_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wbin       <= '0;
      wgray      <= '0;
      rgray_w1   <= '0;
      rgray_w2   <= '0;
      in_ready_o <= 1'b1;
    end
    else
    begin
      wbin       <= next_wbin;
      wgray      <= next_wgray;
      rgray_w1   <= rgray;
      rgray_w2   <= rgray_w1;
      in_ready_o <= next_wgray != (rgray_w2 ^ TOP2);
    end
  end

  // read side: stale write pointer only makes empty pessimistic, never wrong
  always_ff @(posedge rd_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rbin        <= '0;
      rgray       <= '0;
      wgray_r1    <= '0;
      wgray_r2    <= '0;
      out_valid_o <= 1'b0;
    end
    else
    begin
      rbin        <= next_rbin;
      rgray       <= next_rgray;
      wgray_r1    <= wgray;
      wgray_r2    <= wgray_r1;
      out_valid_o <= next_rgray != wgray_r2;
    end
  end
endmodule

module ddr_io_element
  import ddr_io_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic            clk_sys_i,
  input  wire logic            sys_rst_i,
  input  wire logic            strobe_i,
  input  wire logic            wr_clk_i,
  input  wire logic [DQ_W-1:0] dq_i,
  output logic      [DQ_W-1:0] dq_o,
  output logic      [DQ_W-1:0] dq_oe_o,
  output logic                 strobe_o,
  output logic                 strobe_oe_o,
  output logic                 term_en_o,
  input  wire out_mode_e       out_mode_i,
  input  wire logic            cap_bypass_i,
  input  wire logic            rd_fifo_bypass_i,
  input  wire logic            wr_valid_i,
  output logic                 wr_ready_o,
  input  wire wr_entry_s       wr_entry_i,
  output logic                 rd_valid_o,
  input  wire logic            rd_ready_i,
  output rd_word_s             rd_data_o,
  output logic                 rd_overflow_o,
  input  wire logic            gate_req_i,
  input  wire logic            cfg_shift_i,
  input  wire logic            cfg_data_i,
  input  wire logic            cfg_update_i,
  output logic                 cfg_data_o,
  output io_dly_arr_t          io_dly_o,
  output strobe_dly_s          strobe_dly_o
);

  logic              strobe_n;
  logic [DQ_W-1:0]   cap_a;
  logic [DQ_W-1:0]   cap_b;
  logic [DQ_W-1:0]   cap_c;
  logic [2*DQ_W-1:0] pair;
  logic [2*DQ_W-1:0] pair_lo;
  logic              pair_half;
  logic              gate_s1;
  logic              gate_s2;
  logic              rd_push;
  rd_word_s          rd_push_word;
  rd_word_s          rd_word_now;
  logic              gate_off;
  logic              rd_in_ready;
  logic              ovf_tgl;
  logic [2:0]        ovf_sync;
  rd_word_s          byp_s1;
  rd_word_s          byp_s2;
  logic              byp_fifo_s1;
  logic              byp_fifo_s2;
  logic              rd_head_valid;
  rd_word_s          rd_head;
  logic              rd_head_take;
  logic              gate_req_q;
  logic              gate_half;
  logic              gate_eff;
  logic [1:0]        mode_s1;
  logic [1:0]        mode_s2;
  out_mode_e         mode;
  logic              wr_head_valid;
  wr_entry_s         wr_head;
  logic              wr_pop;
  logic [1:0]        slot;
  logic [1:0]        last_slot;
  logic [DQ_W-1:0]   next_dq;
  logic              next_oe;
  logic              ddr_mode;
  logic [CHAIN_W-1:0] chain;

  // inverted strobe clocks the whole capture domain
  assign strobe_n = ~strobe_i;

  // register a on the clock's rising edge, b on its falling edge
  always_ff @(posedge strobe_n or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cap_a <= '0;
    else
      cap_a <= dq_i;
  end

  always_ff @(negedge strobe_n or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cap_b <= '0;
    else
      cap_b <= dq_i;
  end

  // register c moves the falling sample onto a's edge so the pair lines up
  always_ff @(posedge strobe_n or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cap_c <= '0;
    else
      cap_c <= cap_b;
  end

  // capture bypass repeats the single-edge sample in both halves
  assign pair = cap_bypass_i ? {cap_a, cap_a} : {cap_a, cap_c};

  // gate sync: opening waits two strobe edges, closing clears at once so postamble noise is lost
  assign gate_off = sys_rst_i | ~gate_eff;

  always_ff @(posedge strobe_n or posedge gate_off)
  begin
    if (gate_off)
    begin
      gate_s1 <= 1'b0;
      gate_s2 <= 1'b0;
    end
    else
    begin
      gate_s1 <= 1'b1;
      gate_s2 <= gate_s1;
    end
  end

  // gated capture: two ddr pairs build one half-rate word for the fifo
  always_ff @(posedge strobe_n or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pair_lo      <= '0;
      pair_half    <= 1'b0;
      rd_push_word <= '0;
      ovf_tgl      <= 1'b0;
    end
    else
    begin
      if (rd_push && !rd_in_ready)
        ovf_tgl <= ~ovf_tgl;  // memory cannot be stalled, so a full fifo drops the word
      if (!gate_s2)
        pair_half <= 1'b0;
      else if (!pair_half)
      begin
        pair_lo   <= pair;
        pair_half <= 1'b1;
      end
      else
      begin
        rd_push_word <= rd_word_now;  // last word kept for the fifo bypass
        pair_half    <= 1'b0;
      end
    end
  end

  // written at the edge after the one that completes the second pair: a stopped strobe strands the last captured pair
  assign rd_word_now = rd_word_s'({pair, pair_lo});
  assign rd_push     = gate_s2 && pair_half;

  // read fifo: strobe domain to system domain
  async_fifo #(
    .W     ($bits(rd_word_s)),
    .DEPTH (DEPTH)
  ) u_rd_fifo (
    .wr_clk_i    (strobe_n),
    .rd_clk_i    (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (rd_push),
    .in_ready_o  (rd_in_ready),
    .in_data_i   (rd_word_now),
    .out_valid_o (rd_head_valid),
    .out_ready_i (rd_head_take),
    .out_data_o  (rd_head)
  );

  assign rd_head_take = !byp_fifo_s2 && (!rd_valid_o || rd_ready_i);

  // system-side read output; fifo bypass takes a synced copy of the capture word
  // bypass word is multi-bit and only safe while the captured data is steady
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      byp_s1      <= '0;
      byp_s2      <= '0;
      byp_fifo_s1 <= 1'b0;
      byp_fifo_s2 <= 1'b0;
      rd_valid_o  <= 1'b0;
      rd_data_o   <= '0;
    end
    else
    begin
      byp_s1      <= rd_push_word;
      byp_s2      <= byp_s1;
      byp_fifo_s1 <= rd_fifo_bypass_i;
      byp_fifo_s2 <= byp_fifo_s1;
      if (byp_fifo_s2)
      begin
        rd_valid_o <= 1'b1;
        rd_data_o  <= byp_s2;
      end
      else if (!rd_valid_o || rd_ready_i)
      begin
        rd_valid_o <= rd_head_valid;
        rd_data_o  <= rd_head;
      end
    end
  end

  // dropped-word events cross as a toggle and leave as a one-cycle pulse
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ovf_sync      <= '0;
      rd_overflow_o <= 1'b0;
    end
    else
    begin
      ovf_sync      <= {ovf_sync[1:0], ovf_tgl};
      rd_overflow_o <= ovf_sync[2] ^ ovf_sync[1];
    end
  end

  // gating request registered on the half-rate clock, echoed half a cycle later
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      gate_req_q <= 1'b0;
    else
      gate_req_q <= gate_req_i;
  end

  always_ff @(negedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      gate_half <= 1'b0;
    else
      gate_half <= gate_req_q;
  end

  // and of both: rise waits for the late copy, fall follows the early one
  assign gate_eff = gate_req_q & gate_half;

  // write fifo: half-rate core entries into the write-clock domain
  async_fifo #(
    .W     ($bits(wr_entry_s)),
    .DEPTH (DEPTH)
  ) u_wr_fifo (
    .wr_clk_i    (clk_sys_i),
    .rd_clk_i    (wr_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (wr_valid_i),
    .in_ready_o  (wr_ready_o),
    .in_data_i   (wr_entry_i),
    .out_valid_o (wr_head_valid),
    .out_ready_i (wr_pop),
    .out_data_o  (wr_head)
  );

  // mode is quasi-static but still crosses on two flops
  always_ff @(posedge wr_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mode_s1 <= '0;
      mode_s2 <= '0;
    end
    else
    begin
      mode_s1 <= out_mode_i;
      mode_s2 <= mode_s1;
    end
  end

  assign mode     = out_mode_e'(mode_s2);
  assign ddr_mode = (mode == OUT_DDR_FULL) || (mode == OUT_DDR_HALF);

  // slot plan per mode; every mode pops the same half-rate entries, non-half modes after one or two slots
  always_comb
  begin
    unique case (mode)
      OUT_SDR_COMB: last_slot = LAST_SLOT_COMB;
      OUT_SDR_REG:  last_slot = LAST_SLOT_REG;
      OUT_DDR_FULL: last_slot = LAST_SLOT_FULL;
      OUT_DDR_HALF: last_slot = LAST_SLOT_HALF;
    endcase
  end

  // word and enable picked by the same slot, so both see one latency
  always_comb
  begin
    unique case (mode)
      OUT_SDR_COMB,
      OUT_SDR_REG:
      begin
        next_dq = wr_head.word[0];
        next_oe = wr_head.oe[0];
      end
      OUT_DDR_FULL:
      begin
        next_dq = wr_head.word[slot[0]];
        next_oe = wr_head.oe[0];
      end
      OUT_DDR_HALF:
      begin
        next_dq = wr_head.word[slot];
        next_oe = wr_head.oe[slot[1]];
      end
    endcase
  end

  assign wr_pop = wr_head_valid && (slot == last_slot);

  // ddr output registers for data, enable and termination on the write clock
  always_ff @(posedge wr_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      slot      <= '0;
      dq_o      <= '0;
      dq_oe_o   <= '0;
      term_en_o <= 1'b0;
    end
    else if (wr_head_valid)
    begin
      slot      <= (slot == last_slot) ? 2'h0 : slot + 2'h1;
      dq_o      <= next_dq;
      dq_oe_o   <= {DQ_W{next_oe}};
      term_en_o <= ~next_oe;              // termination on only while not driving
    end
    else
    begin
      slot      <= '0;
      dq_oe_o   <= '0;                    // underrun releases the pins
      term_en_o <= 1'b1;
    end
  end

  // strobe launched half a write-clock period after data: 90 degrees of its own period
  always_ff @(negedge wr_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      strobe_o    <= 1'b0;
      strobe_oe_o <= 1'b0;
    end
    else
    begin
      strobe_oe_o <= dq_oe_o[0];
      strobe_o    <= (ddr_mode && dq_oe_o[0]) ? ~strobe_o : 1'b0;
    end
  end

  // serial config chain: one bit per clock while shifting, pins first, strobe last
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      chain      <= '0;
      cfg_data_o <= 1'b0;
    end
    else if (cfg_shift_i)
    begin
      chain      <= {chain[CHAIN_W-2:0], cfg_data_i};
      cfg_data_o <= chain[CHAIN_W-1];
    end
  end

  // shadow settings feed the delay chains; partial shifts never reach them
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      io_dly_o     <= {(NPIN*4){DLY_RESET}};
      strobe_dly_o <= {2{DLY_RESET}};
    end
    else if (cfg_update_i)
    begin
      io_dly_o     <= io_dly_arr_t'(chain[CHAIN_W-1:STB_CFG_W]);
      strobe_dly_o <= strobe_dly_s'(chain[STB_CFG_W-1:0]);
    end
  end

endmodule

//--- logic/ddr_io_pkg.sv
// shared constants, modes and carrier types for the ddr i/o element datapath
package ddr_io_pkg;

  // pin and word geometry
  localparam int DQ_W        = 8;            // data pins handled by one element group
  localparam int NPIN        = DQ_W + 1;     // data pins plus the strobe pin
  localparam int WORDS_HALF  = 4;            // write words per half-rate entry
  localparam int OE_HALF     = 2;            // output-enable bits per half-rate entry
  localparam int RD_SAMPLES  = 4;            // captured samples per read word

  // delay chain settings
  localparam int DLY_W       = 5;            // tap code width of one delay chain
  localparam int IO_CFG_W    = 4 * DLY_W;    // four chains per i/o block
  localparam int STB_CFG_W   = 2 * DLY_W;    // two chains per strobe logic block
  localparam int CHAIN_W     = NPIN * IO_CFG_W + STB_CFG_W;
  localparam logic [DLY_W-1:0] DLY_RESET = 5'h00;  // all config bits power up low

  // buffering
  localparam int FIFO_DEPTH  = 4;

  // output path modes
  typedef enum logic [1:0] {
    OUT_SDR_COMB,
    OUT_SDR_REG,
    OUT_DDR_FULL,
    OUT_DDR_HALF
  } out_mode_e;

  // last slot index per fifo entry, one slot per write-clock rising edge (half a full-rate cycle)
  localparam logic [1:0] LAST_SLOT_COMB = 2'h0;
  localparam logic [1:0] LAST_SLOT_REG  = 2'h1;
  localparam logic [1:0] LAST_SLOT_FULL = 2'h1;
  localparam logic [1:0] LAST_SLOT_HALF = 2'h3;

  // one half-rate write entry from the core
  typedef struct packed {
    logic [OE_HALF-1:0]                oe;
    logic [WORDS_HALF-1:0][DQ_W-1:0]   word;  // word[0] goes out first
  } wr_entry_s;

  // one half-rate read word: two ddr pairs, sample[0] oldest
  typedef struct packed {
    logic [RD_SAMPLES-1:0][DQ_W-1:0]   sample;
  } rd_word_s;

  // delay settings of one i/o block
  typedef struct packed {
    logic [DLY_W-1:0] out_dly;   // output register to output buffer
    logic [DLY_W-1:0] in_dly;    // input buffer to input register
    logic [DLY_W-1:0] oe_dly;    // output enable to output buffer
    logic [DLY_W-1:0] term_dly;  // termination-enable register to buffer
  } io_dly_s;

  // delay settings of the strobe logic block
  typedef struct packed {
    logic [DLY_W-1:0] strobe_dly;  // after the distributed strobe output
    logic [DLY_W-1:0] gate_dly;    // before the strobe gating enable input
  } strobe_dly_s;

  typedef io_dly_s [NPIN-1:0] io_dly_arr_t;

endpackage

//--- tb/ddr_io_element_assertions.sv
// concurrent checks on the ports of the ddr i/o element datapath
`timescale 1ns/100ps
module ddr_io_element_checker
  import ddr_io_pkg::*;
(
  input wire logic            clk_sys_i,
  input wire logic            sys_rst_i,
  input wire logic            wr_clk_i,
  input wire logic [DQ_W-1:0] dq_oe_o,
  input wire logic            strobe_o,
  input wire logic            strobe_oe_o,
  input wire logic            term_en_o,
  input wire out_mode_e       out_mode_i,
  input wire logic            rd_fifo_bypass_i,
  input wire logic            wr_valid_i,
  input wire logic            wr_ready_o,
  input wire logic            rd_valid_o,
  input wire logic            rd_ready_i,
  input wire rd_word_s        rd_data_o,
  input wire logic            cfg_shift_i,
  input wire logic            cfg_data_i,
  input wire logic            cfg_update_i,
  input wire logic            cfg_data_o,
  input wire io_dly_arr_t     io_dly_o,
  input wire strobe_dly_s     strobe_dly_o
);
  // last bits shifted in; an update must land them in the strobe block
  logic [STB_CFG_W-1:0] tail;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      tail <= '0;
    else if (cfg_shift_i)
      tail <= {tail[STB_CFG_W-2:0], cfg_data_i};
  end

  chk_term_inverse: assert property (@(posedge wr_clk_i) disable iff (sys_rst_i)
    $past(!sys_rst_i) |-> term_en_o == !dq_oe_o[0]) else $error("termination not opposite to enable");
  chk_oe_uniform: assert property (@(posedge wr_clk_i) disable iff (sys_rst_i)
    dq_oe_o == {DQ_W{dq_oe_o[0]}}) else $error("data enables disagree");
  chk_strobe_oe_follow: assert property (@(posedge wr_clk_i) disable iff (sys_rst_i)
    $past(!sys_rst_i) |-> strobe_oe_o == dq_oe_o[0]) else $error("strobe enable not half a slot behind");
  chk_strobe_toggles: assert property (@(posedge wr_clk_i) disable iff (sys_rst_i)
    out_mode_i inside {OUT_DDR_FULL, OUT_DDR_HALF} && $past(out_mode_i, 4) == out_mode_i
    && strobe_oe_o && $past(strobe_oe_o) |-> strobe_o != $past(strobe_o)) else $error("strobe did not toggle");
  chk_ready_cause: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(wr_ready_o) |-> $past(wr_valid_i)) else $error("ready fell without a push");
  chk_shift_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !cfg_shift_i |=> $stable(cfg_data_o)) else $error("serial out moved without shift");
  chk_update_only: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !cfg_update_i |=> $stable(io_dly_o) && $stable(strobe_dly_o)) else $error("delays moved without update");
  chk_update_copy: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    cfg_update_i && !cfg_shift_i |=> strobe_dly_o == $past(tail)) else $error("strobe delays not copied");
  chk_read_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    rd_valid_o && !rd_ready_i && !rd_fifo_bypass_i |=> rd_valid_o && $stable(rd_data_o))
    else $error("read word dropped while stalled");
endmodule

bind ddr_io_element ddr_io_element_checker chk (.clk_sys_i, .sys_rst_i, .wr_clk_i, .dq_oe_o, .strobe_o,
  .strobe_oe_o, .term_en_o, .out_mode_i, .rd_fifo_bypass_i, .wr_valid_i, .wr_ready_o, .rd_valid_o,
  .rd_ready_i, .rd_data_o, .cfg_shift_i, .cfg_data_i, .cfg_update_i, .cfg_data_o, .io_dly_o, .strobe_dly_o);

//--- tb/ddr_mem_model.sv
// read side of the external memory: data always driven, strobe pulsed inside frames and by post-frame noise
`timescale 1ns/100ps
module ddr_mem_model
  import ddr_io_pkg::*;
(
  output logic            strobe_o,
  output logic [DQ_W-1:0] dq_o
);
  // strobe parks low between frames, like a postamble
  initial
  begin
    strobe_o = 1'b0;
    dq_o     = 8'h5a;
  end

  // identical pairs, data centred on each strobe edge at a 6 ns strobe period
  task automatic burst(input logic [DQ_W-1:0] hi_val, input logic [DQ_W-1:0] lo_val, input int pairs);
    for (int p = 0; p < pairs; p++)
    begin
      dq_o = hi_val;
      #1.5 strobe_o = 1'b1;
      #1.5 dq_o = lo_val;
      #1.5 strobe_o = 1'b0;
      #1.5;
    end
    dq_o = ~lo_val;  // released lines never keep the last value
  endtask

  // noise on the strobe after the frame; must never reach the read words
  task automatic glitch;
    dq_o = ~dq_o;
    repeat (2)
    begin
      #1 strobe_o = 1'b1;
      #1 strobe_o = 1'b0;
    end
  endtask
endmodule

//--- tb/tb_ddr_io_element.sv
// self-checking bench for the ddr i/o element datapath
`timescale 1ns/100ps
module tb_ddr_io_element;
  import ddr_io_pkg::*;
  logic            clk_sys_i    = 1'b0;
  logic            wr_clk_i     = 1'b0;
  logic            sys_rst_i    = 1'b1;
  out_mode_e       out_mode_i   = OUT_DDR_HALF;
  logic            cap_bypass_i = 1'b0;
  logic            wr_valid_i   = 1'b0;
  wr_entry_s       wr_entry_i   = '0;
  logic            rd_ready_i   = 1'b0;
  logic            gate_req_i   = 1'b0;
  logic            cfg_shift_i  = 1'b0;
  logic            cfg_data_i   = 1'b0;
  logic            cfg_update_i = 1'b0;
  logic            rd_fifo_bypass_i = 1'b0;
  logic            byp_quiet    = 1'b0;
  logic            rd_overflow_o;
  rd_word_s        last_rd;
  wire logic       strobe;
  wire [DQ_W-1:0]  dq_in;
  logic [DQ_W-1:0] dq_o;
  logic [DQ_W-1:0] dq_oe_o;
  logic            strobe_o;
  logic            strobe_oe_o;
  logic            term_en_o;
  logic            wr_ready_o;
  logic            rd_valid_o;
  rd_word_s        rd_data_o;
  logic            cfg_data_o;
  io_dly_arr_t     io_dly_o;
  strobe_dly_s     strobe_dly_o;
  logic [DQ_W-1:0] wq[$];
  rd_word_s        rq[$];
  int              fail_count = 0;
  int              compares   = 0;
  integer          seed       = 12;

  // system clock 8 ns, write clock 6 ns with its own phase
  always #4 clk_sys_i = ~clk_sys_i;
  always #3 wr_clk_i = ~wr_clk_i;

  ddr_io_element #(.DEPTH(FIFO_DEPTH)) DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .strobe_i(strobe),
    .wr_clk_i(wr_clk_i), .dq_i(dq_in), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .strobe_o(strobe_o),
    .strobe_oe_o(strobe_oe_o), .term_en_o(term_en_o), .out_mode_i(out_mode_i), .cap_bypass_i(cap_bypass_i),
    .rd_fifo_bypass_i(rd_fifo_bypass_i), .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
    .wr_entry_i(wr_entry_i), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o),
    .rd_overflow_o(rd_overflow_o),
    .gate_req_i(gate_req_i), .cfg_shift_i(cfg_shift_i), .cfg_data_i(cfg_data_i), .cfg_update_i(cfg_update_i),
    .cfg_data_o(cfg_data_o), .io_dly_o(io_dly_o), .strobe_dly_o(strobe_dly_o));
  ddr_mem_model mem (.strobe_o(strobe), .dq_o(dq_in));

  task automatic cmp(input logic [199:0] got, input logic [199:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL at %0t: %s", $time, m);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // consumer stalls at random, so read words must wait
  always @(posedge clk_sys_i)
    rd_ready_i <= byp_quiet || (($random(seed) % 4) != 0);

  // no read word may be dropped in these scenarios
  always @(posedge clk_sys_i)
    if (!sys_rst_i && rd_overflow_o !== 1'b0)
      cmp(200'(rd_overflow_o), '0, "read word dropped");

  // each driven slot takes the oldest expected word; an empty queue forces a mismatch
  always @(posedge wr_clk_i)
    if (!sys_rst_i && dq_oe_o[0] === 1'b1)
      cmp(200'(dq_o), wq.size() > 0 ? 200'(wq.pop_front()) : 'x, "write slot");

  // each accepted read word takes the oldest expected word
  always @(posedge clk_sys_i)
    if (!sys_rst_i && !byp_quiet && rd_valid_o === 1'b1 && rd_ready_i === 1'b1)
      cmp(200'(rd_data_o), rq.size() > 0 ? 200'(rq.pop_front()) : 'x, "read word");

  // serial load, checking the old chain as it falls out, then one update
  task automatic load(input logic [CHAIN_W-1:0] v, input logic [CHAIN_W-1:0] old);
    for (int i = CHAIN_W - 1; i >= 0; i--)
    begin
      @(posedge clk_sys_i);
      if (i < CHAIN_W - 2)
        cmp(200'(cfg_data_o), 200'(old[i+2]), "shift out");
      cfg_shift_i <= 1'b1;
      cfg_data_i  <= v[i];
    end
    @(posedge clk_sys_i);
    cmp(200'(cfg_data_o), 200'(old[1]), "shift out");
    cfg_shift_i <= 1'b0;
    @(posedge clk_sys_i);
    cmp(200'(cfg_data_o), 200'(old[0]), "shift out");
    cmp(200'({io_dly_o, strobe_dly_o}), 200'(old), "delays before update");
    cfg_update_i <= 1'b1;
    @(posedge clk_sys_i);
    cfg_update_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    cmp(200'({io_dly_o, strobe_dly_o}), 200'(v), "delays after update");
    $display("test config load done");
  endtask

  // six entries, more than the buffer holds, so the core side is stalled
  task automatic write_mode(input out_mode_e m);
    wr_entry_s e;
    int        k;
    out_mode_i <= m;
    repeat (6) @(posedge clk_sys_i);
    for (int n = 0; n < 6; n++)
    begin
      e = wr_entry_s'(34'({$random(seed), $random(seed)}));
      e.oe[0] = e.oe[0] | (n < 4);
      wr_valid_i <= 1'b1;
      wr_entry_i <= e;
      do @(posedge clk_sys_i); while (wr_ready_o !== 1'b1);
      for (int i = 0; i < ((m == OUT_DDR_HALF) ? 4 : (m == OUT_SDR_COMB) ? 1 : 2); i++)
      begin
        k = (m == OUT_SDR_REG) ? 0 : i;
        if (e.oe[k/2])
          wq.push_back(e.word[k]);
      end
    end
    wr_valid_i <= 1'b0;
    repeat (30) @(posedge clk_sys_i);
    cmp(200'(wq.size()), '0, "write words missing");
    $display("test write mode %0d done", m);
  endtask

  // one gated frame of ten pairs; the first two strobe edges only open the gate
  task automatic read_burst(input logic bypass);
    logic [DQ_W-1:0] a;
    logic [DQ_W-1:0] b;
    a = 8'($random(seed));
    b = 8'($random(seed));
    cap_bypass_i <= bypass;
    gate_req_i   <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    last_rd = rd_word_s'(bypass ? {a, a, a, a} : {a, b, a, b});
    repeat (4) rq.push_back(last_rd);
    mem.burst(b, a, 10);
    @(posedge clk_sys_i);
    gate_req_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    mem.glitch();
    repeat (25) @(posedge clk_sys_i);
    cmp(200'(rq.size()), '0, "read words missing");
    $display("test read burst bypass %0d done", bypass);
  endtask

  // fifo bypass shows the last captured word; the consumer is held ready and ignored meanwhile
  task automatic fifo_bypass;
    rd_fifo_bypass_i <= 1'b1;
    byp_quiet        <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    cmp(200'({rd_valid_o, rd_data_o}), 200'({1'b1, last_rd}), "bypass word");
    rd_fifo_bypass_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    cmp(200'(rd_valid_o), '0, "bypass left valid");
    byp_quiet <= 1'b0;
    $display("test fifo bypass done");
  endtask

  initial
  begin
    logic [CHAIN_W-1:0] c1;
    logic [CHAIN_W-1:0] c2;
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    cmp(200'({term_en_o, dq_oe_o, wr_ready_o}), 200'({1'b1, 8'h00, 1'b1}), "idle after reset");
    for (int j = 0; j < 14; j++)
      c1 = {c1[CHAIN_W-33:0], 32'($random(seed))};
    for (int j = 0; j < 7; j++)
      c2 = {c2[CHAIN_W-33:0], 32'($random(seed))};
    load(c1, '0);
    load(c2, c1);
    for (int m = 0; m < 4; m++)
      write_mode(out_mode_e'(m));
    read_burst(1'b0);
    read_burst(1'b1);
    fifo_bypass();
    conclude;
  end

  // a hang counts as a mismatch and ends the run the same way
  initial
  begin
    #100000;
    fail_count++;
    conclude;
  end
endmodule
